// ==== core/conv_seq_ctrl.sv ====
// sequencing of filter sync, standby, reset and data-ready for the converter
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module conv_seq_ctrl (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [15:0] sample_word,
    output logic modulator_hold,
    output logic power_down,
    output logic word_available_n,
    output logic mclk_out
);
    import conv_seq_pkg::*;

    // counter step that stops at the top instead of wrapping
    function automatic logic [23:0] sat_inc(input logic [23:0] v);
        sat_inc = (v == 24'hFFFFFF) ? v : v + 24'h000001;
    endfunction : sat_inc

    // registers
    logic [7:0] ctrl_q; // sync, power-down, config
    logic [7:0] ctrl_d;
    logic [15:0] rate_q; // word period in clocks
    logic [15:0] rate_d;
    logic [15:0] data_q; // output data word
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    logic waitrequest_q;
    logic hold_q;
    logic pd_q;
    logic word_available_n_q;
    logic word_available_n_d;
    logic mclk_out_q;
    // sequencer
    seq_state_e state_q;
    seq_state_e state_d;
    logic [15:0] period_cnt_q;
    logic [15:0] period_cnt_d;
    logic [1:0] word_cnt_q;
    logic [1:0] word_cnt_d;
    // ready pulse
    logic pulse_q;
    logic pulse_d;
    logic [9:0] pulse_cnt_q;
    logic [9:0] pulse_cnt_d;
    // cycles since leaving hold, only the checks read it
    logic [23:0] since_rel_q;

    // bus decode
    wire req = read | write;
    wire take = req & ~waitrequest_q; // access completes here
    wire wr_take = take & write;
    wire rd_take = take & read;
    wire sel_ctrl = (address == CTRL_OFS);
    wire sel_stat = (address == STAT_OFS);
    wire sel_data = (address == DATA_OFS);
    wire sel_rate = (address == RATE_OFS);
    wire data_rd = rd_take & sel_data;
    wire hold_src = ctrl_q[FILTER_SYNC_HOLD_BIT_BIT] | ctrl_q[PD_BIT];
    // a zero period would wrap round to the longest period of the 16-bit counter
    wire [15:0] rate_eff = (rate_q < RATE_MIN) ? RATE_MIN : rate_q;
    wire period_end = (period_cnt_q == rate_eff - 16'h0001);
    wire settle_done = period_end & (word_cnt_q == SETTLE_LAST);
    // update strobe of the output data register
    wire upd = ((state_q == S_SETTLE) & settle_done)
        | ((state_q == S_RUN) & period_end);
    wire pulse_end = pulse_q & (pulse_cnt_q == PULSE_LAST);
    wire [31:0] stat_word = {28'h0000000, state_q, hold_q, word_available_n_q};

    // control register write, byte lane 0 only
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_take && sel_ctrl && byteenable[0])
        begin
            // the whole byte is replaced through the mask, so sync writes also overwrite config
            ctrl_d = writedata[7:0] & CTRL_MASK;
        end
    end

    // rate register write, low two lanes
    always_comb
    begin
        rate_d = rate_q;
        if (wr_take && sel_rate)
        begin
            if (byteenable[0])
            begin
                rate_d[7:0] = writedata[7:0];
            end
            if (byteenable[1])
            begin
                rate_d[15:8] = writedata[15:8];
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb
    begin
        readdata_d = 32'h00000000;
        if (sel_ctrl)
        begin
            readdata_d = {24'h000000, ctrl_q};
        end
        else if (sel_stat)
        begin
            readdata_d = stat_word;
        end
        else if (sel_data)
        begin
            readdata_d = {16'h0000, data_q};
        end
        else if (sel_rate)
        begin
            readdata_d = {16'h0000, rate_q};
        end
    end

    // sequencer: hold, settle three periods, then free run
    always_comb
    begin
        state_d = state_q;
        period_cnt_d = period_end ? 16'h0000 : period_cnt_q + 16'h0001;
        word_cnt_d = word_cnt_q;
        case (state_q)
            S_HOLD:
            begin
                // filter and modulator frozen, no samples
                period_cnt_d = 16'h0000;
                word_cnt_d = 2'h0;
                if (!hold_src)
                begin
                    state_d = S_SETTLE;
                end
            end
            S_SETTLE:
            begin
                // settling restarts from every release
                if (settle_done)
                begin
                    state_d = S_RUN;
                end
                else if (period_end)
                begin
                    word_cnt_d = word_cnt_q + 2'h1;
                end
            end
            S_RUN:
            begin
                word_cnt_d = 2'h0;
            end
            default:
            begin
                state_d = S_HOLD;
            end
        endcase
        // sync or power-down wins from any state
        if (hold_src)
        begin
            state_d = S_HOLD;
            period_cnt_d = 16'h0000;
            word_cnt_d = 2'h0;
        end
    end

    // data-ready: new word wins over a read in the same cycle
    always_comb
    begin
        word_available_n_d = word_available_n_q;
        pulse_d = pulse_q;
        pulse_cnt_d = pulse_q ? pulse_cnt_q + 10'h001 : 10'h000;
        if (upd && !word_available_n_q)
        begin
            // unread word replaced: raise first, fall later
            word_available_n_d = 1'b1;
            pulse_d = 1'b1;
            pulse_cnt_d = 10'h000;
        end
        else if (upd)
        begin
            word_available_n_d = 1'b0;
        end
        else if (data_rd)
        begin
            // read retires the word and cancels a pending fall
            word_available_n_d = 1'b1;
            pulse_d = 1'b0;
        end
        else if (pulse_end)
        begin
            word_available_n_d = 1'b0;
            pulse_d = 1'b0;
        end
    end

    // bus slave and registers, level reset holds everything
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // wait held high, so no access completes
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h00000000;
            ctrl_q <= CTRL_RESET;
            rate_q <= RATE_RESET;
        end
        else
        begin
            // one wait cycle, then a single ready cycle
            waitrequest_q <= ~(req & waitrequest_q);
            readdata_q <= readdata_d;
            ctrl_q <= ctrl_d;
            rate_q <= rate_d;
        end
    end

    // data word, kept through standby and sync
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            data_q <= 16'h0000;
        end
        else if (upd)
        begin
            data_q <= sample_word;
        end
    end

    // sequencer and ready registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= S_HOLD;
            period_cnt_q <= 16'h0000;
            word_cnt_q <= 2'h0;
            word_available_n_q <= 1'b1;
            pulse_q <= 1'b0;
            pulse_cnt_q <= 10'h000;
            hold_q <= 1'b1;
            pd_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            period_cnt_q <= period_cnt_d;
            word_cnt_q <= word_cnt_d;
            word_available_n_q <= word_available_n_d;
            pulse_q <= pulse_d;
            pulse_cnt_q <= pulse_cnt_d;
            hold_q <= hold_src;
            pd_q <= ctrl_q[PD_BIT];
        end
    end

    // cycles since release, for the settling check
    always_ff @(posedge clock)
    begin
        if (!rst_n || state_q == S_HOLD)
        begin
            since_rel_q <= 24'h000000;
        end
        else
        begin
            since_rel_q <= sat_inc(since_rel_q);
        end
    end

    // clock output has no reset so it never stops;
    // an unknown start value takes the else branch and settles
    always_ff @(posedge clock)
    begin
        if (mclk_out_q)
            mclk_out_q <= 1'b0;
        else
            mclk_out_q <= 1'b1;
    end

    // outputs straight from flip-flops
    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;
    assign modulator_hold = hold_q;
    assign power_down = pd_q;
    assign word_available_n = word_available_n_q;
    assign mclk_out = mclk_out_q;

    // checks
    property p_hold_no_upd;
        @(posedge clock) disable iff (!rst_n)
        hold_src |=> (state_q == S_HOLD) && !upd;
    endproperty
    a_hold_no_upd: assert property (p_hold_no_upd)
        else $error("sample taken while held");

    property p_release;
        @(posedge clock) disable iff (!rst_n)
        (state_q == S_HOLD) && !hold_src |=> state_q == S_SETTLE ##1 period_cnt_q == 16'h0001;
    endproperty
    a_release: assert property (p_release)
        else $error("sampling did not resume");

    property p_cfg_kept;
        @(posedge clock) disable iff (!rst_n)
        $changed(ctrl_q[FILTER_SYNC_HOLD_BIT_BIT]) |-> $stable(rate_q);
    endproperty
    a_cfg_kept: assert property (p_cfg_kept)
        else $error("sync bit disturbed setup");

    property p_settle;
        @(posedge clock) disable iff (!rst_n)
        upd && state_q == S_SETTLE |-> {8'h00, since_rel_q} == 3 * {16'h0000, rate_eff} - 1;
    endproperty
    a_settle: assert property (p_settle)
        else $error("word loaded before settling");

    property p_pulse_start;
        @(posedge clock) disable iff (!rst_n)
        upd && !word_available_n_q |=> word_available_n_q && pulse_q && pulse_cnt_q == 10'h000;
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("ready pulse did not start");

    property p_pulse_end;
        @(posedge clock) disable iff (!rst_n)
        pulse_end && !upd && !data_rd |=> !word_available_n_q && !pulse_q;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("ready pulse did not end");

    property p_read_clears;
        @(posedge clock) disable iff (!rst_n)
        data_rd && !upd |=> word_available_n_q;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("read did not raise ready");

    property p_reset_hold;
        @(posedge clock)
        !rst_n |=> word_available_n_q && waitrequest_q;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset did not hold ready and wait");

    property p_standby_bus;
        @(posedge clock) disable iff (!rst_n)
        ctrl_q[PD_BIT] && req && waitrequest_q |=> !waitrequest_q;
    endproperty
    a_standby_bus: assert property (p_standby_bus)
        else $error("bus stalled in standby");

    property p_clk_runs;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> mclk_out_q != $past(mclk_out_q);
    endproperty
    a_clk_runs: assert property (p_clk_runs)
        else $error("clock output stopped");

    c_first_word: cover property (@(posedge clock) upd && state_q == S_SETTLE);
    c_pulse: cover property (@(posedge clock) pulse_end);
    c_standby_read: cover property (@(posedge clock) data_rd && ctrl_q[PD_BIT]);
endmodule : conv_seq_ctrl

// ==== core/conv_seq_pkg.sv ====
// constants and types shared by the conversion sequencing block
package conv_seq_pkg;
    // register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] DATA_OFS = 4'h8;
    localparam logic [3:0] RATE_OFS = 4'hC;
    // control field positions
    localparam int FILTER_SYNC_HOLD_BIT_BIT = 0;
    localparam int PD_BIT = 1;
    localparam int CFG_LSB = 4;
    localparam int CFG_MSB = 7;
    // control reset and writable mask
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hF3;
    // word period in master clocks, reset value and floor
    localparam logic [15:0] RATE_RESET = 16'h0100;
    localparam logic [15:0] RATE_MIN = 16'h0004;
    // settling spans this many word periods; last index of it
    localparam logic [1:0] SETTLE_LAST = 2'h2;
    // master clock period and ready pulse
    localparam int CLK_PERIOD_NS = 5;
    localparam int PULSE_NS = 2500;
    localparam int PULSE_CYC_I = PULSE_NS / CLK_PERIOD_NS;
    localparam logic [9:0] PULSE_LAST = 10'(PULSE_CYC_I - 1);
    // sequencer states
    typedef enum logic [1:0] {
        S_HOLD = 2'b00,
        S_SETTLE = 2'b01,
        S_RUN = 2'b10
    } seq_state_e;
endpackage : conv_seq_pkg

// ==== tb/sample_source.sv ====
// far-side filter model feeding sample words
`timescale 1ns/1ps
module sample_source (
    input wire logic clock,
    output logic [15:0] sample_word
);
    // new word every clock, so a stale load is visible
    initial sample_word = 16'h1234;
    always @(posedge clock)
    begin
        sample_word <= sample_word + 16'h0001;
    end
endmodule : sample_source

// ==== tb/tb_conv_seq_ctrl.sv ====
// self-checking bench for the conversion sequencing block
`timescale 1ns/1ps
module tb_conv_seq_ctrl;
    import conv_seq_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic modulator_hold;
    logic power_down;
    logic word_available_n;
    logic mclk_out;
    logic [15:0] sample_word;
    logic [31:0] rd; // last read data
    logic [31:0] keep; // word held over standby
    int errors = 0;
    int tests_run = 0;
    int n;
    // 200 MHz
    always #2.5 clock = ~clock;
    conv_seq_ctrl u_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .sample_word(sample_word),
        .modulator_hold(modulator_hold), .power_down(power_down),
        .word_available_n(word_available_n), .mclk_out(mclk_out));
    sample_source u_src (.clock(clock), .sample_word(sample_word));
    // value compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // cycle count compare, window absorbs pipeline slack only
    task automatic chk_span(input string what, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_span
    // one avalon access; entered just after a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        // values read here are those that this rising edge sampled
        @(posedge clock);
        k++;
        while (waitrequest !== 1'b0)
        begin
            @(posedge clock);
            k++;
        end
        // the edge that saw waitrequest low took the access
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        chk("bus answer", 32'h00000002, 32'(k));
        // idle edge so the strobe is never set twice in one step
        @(posedge clock);
    endtask : bus
    // count cycles until ready shows the given level
    task automatic wait_level(input logic lvl, input int max);
        n = 0;
        while (word_available_n !== lvl && n < max)
        begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
    endtask : wait_level
    // clock output must toggle
    task automatic mclk_chk();
        logic m;
        @(negedge clock);
        m = ~mclk_out;
        @(negedge clock);
        chk("mclk_out", 32'(m), 32'(mclk_out));
        @(posedge clock);
    endtask : mclk_chk
    // sync hold, release and settle with ready high
    task automatic t_sync();
        bus(1'b1, RATE_OFS, 32'h8);
        bus(1'b0, DATA_OFS, 32'h0);
        bus(1'b1, CTRL_OFS, 32'h31);
        // hold output follows the control register one edge later
        @(posedge clock);
        chk("modulator_hold", 32'(1'b1), 32'(modulator_hold));
        repeat (40) @(posedge clock);
        chk("ready held", 32'(1'b1), 32'(word_available_n));
        bus(1'b0, STAT_OFS, 32'h0);
        chk("status held", 32'h00000003, rd);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", 32'h31, rd);
        bus(1'b0, RATE_OFS, 32'h0);
        chk("rate", 32'h8, rd);
        bus(1'b1, CTRL_OFS, 32'h30);
        wait_level(1'b0, 100);
        chk_span("settle", 21, 27, n);
        chk("modulator_hold", 32'(1'b0), 32'(modulator_hold));
        bus(1'b0, DATA_OFS, 32'h0);
        chk("ready after read", 32'(1'b1), 32'(word_available_n));
        $display("test sync done");
    endtask : t_sync
    // shared: ready low at release, then settle and a 500 clock pulse
    task automatic pulse_after_release();
        chk("ready at release", 32'(1'b0), 32'(word_available_n));
        wait_level(1'b1, 2000);
        chk_span("settle long", 1797, 1803, n);
        wait_level(1'b0, 600);
        chk_span("pulse", 500, 500, n);
    endtask : pulse_after_release
    // sync release with an unread word
    task automatic t_pulse();
        bus(1'b1, RATE_OFS, 32'h258);
        wait_level(1'b0, 700);
        bus(1'b1, CTRL_OFS, 32'h01);
        bus(1'b1, CTRL_OFS, 32'h00);
        pulse_after_release();
        $display("test pulse done");
    endtask : t_pulse
    // standby entry, read in standby, wake
    task automatic t_standby();
        bus(1'b1, CTRL_OFS, 32'h02);
        // standby output follows the control register one edge later
        @(posedge clock);
        chk("power_down", 32'(1'b1), 32'(power_down));
        repeat (700) @(posedge clock);
        chk("ready in standby", 32'(1'b0), 32'(word_available_n));
        mclk_chk();
        bus(1'b1, CTRL_OFS, 32'h00);
        pulse_after_release();
        bus(1'b1, CTRL_OFS, 32'h02);
        bus(1'b0, DATA_OFS, 32'h0);
        keep = rd;
        chk("ready after standby read", 32'(1'b1), 32'(word_available_n));
        repeat (700) @(posedge clock);
        bus(1'b0, DATA_OFS, 32'h0);
        chk("data kept", keep, rd);
        bus(1'b1, CTRL_OFS, 32'h00);
        wait_level(1'b0, 2000);
        chk_span("wake settle", 1797, 1803, n);
        $display("test standby done");
    endtask : t_standby
    // mid-run reset with an access attempted during it
    task automatic t_reset();
        bus(1'b1, CTRL_OFS, 32'h30);
        rst_n <= 1'b0;
        address <= CTRL_OFS;
        writedata <= 32'h31;
        write <= 1'b1;
        repeat (5) @(posedge clock);
        chk("ready in reset", 32'(1'b1), 32'(word_available_n));
        chk("waitrequest in reset", 32'(1'b1), 32'(waitrequest));
        mclk_chk();
        write <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        wait_level(1'b0, 1000);
        chk_span("first word", 765, 772, n);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl default", 32'(CTRL_RESET), rd);
        bus(1'b0, RATE_OFS, 32'h0);
        chk("rate default", 32'(RATE_RESET), rd);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset
    // verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_sync();
        t_pulse();
        t_standby();
        t_reset();
        final_report();
    end
    // watchdog, run needs about 9300 cycles
    initial
    begin
        #200000;
        errors++;
        $display("ERROR watchdog expected finish seen timeout");
        final_report();
    end
endmodule : tb_conv_seq_ctrl
